//--- hdl/piqu_unit.sv
// identification query unit: decodes a leaf and returns four result words
`timescale 1ns/1ps
`default_nettype none

module piqu_unit (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic query_valid,
	input wire logic [31:0] query_leaf,
	input wire logic pipe_drained,
	input wire logic serial_number_feature,
	input wire logic [63:0] serial_number,
	input wire logic flag_wr,
	input wire logic flag_wdata,
	output logic ident_support_flag,
	output logic busy,
	output logic res_valid,
	output logic [31:0] res_eax,
	output logic [31:0] res_ebx,
	output logic [31:0] res_ecx,
	output logic [31:0] res_edx
);

	////////////////////////////////////////////////////////////////////////////
	// reset release

	logic rst_meta_b;
	logic rst_sync_b;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_b <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_meta_b <= 1'b1;
			rst_sync_b <= rst_meta_b;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// string tables

	function automatic logic [31:0] name_word(input logic [3:0] idx);
		case (idx)
			4'h0: name_word = piqu_pkg::NAME_W0;
			4'h1: name_word = piqu_pkg::NAME_W1;
			4'h2: name_word = piqu_pkg::NAME_W2;
			// the name fills all sixteen characters, so no terminator follows
			4'h3: name_word = piqu_pkg::NAME_W3;
			default: name_word = piqu_pkg::ZERO_WORD;
		endcase
	endfunction

	function automatic logic [31:0] info_word(input logic [3:0] idx);
		case (idx)
			4'h0: info_word = piqu_pkg::INFO_W0;
			4'h1: info_word = piqu_pkg::INFO_W1;
			4'h2: info_word = piqu_pkg::INFO_W2;
			default: info_word = piqu_pkg::ZERO_WORD;
		endcase
	endfunction

	function automatic logic [7:0] hex_char(input logic [3:0] nib);
		if (nib < piqu_pkg::HEX_TEN) begin
			hex_char = piqu_pkg::HEX_DIGIT_BASE + {4'h0, nib};
		end else begin
			hex_char = piqu_pkg::HEX_ALPHA_BASE + {4'h0, nib};
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// sequencing

	piqu_pkg::piqu_state_e state;
	piqu_pkg::piqu_state_e next_state;
	logic [31:0] leaf;

	wire accept = (state == piqu_pkg::PIQU_IDLE) && query_valid;
	// results are held back until all earlier work has drained
	wire complete = (state == piqu_pkg::PIQU_DRAIN) && pipe_drained;

	always_comb begin
		case (state)
			piqu_pkg::PIQU_IDLE: next_state = query_valid ? piqu_pkg::PIQU_DRAIN : state;
			piqu_pkg::PIQU_DRAIN: next_state = pipe_drained ? piqu_pkg::PIQU_IDLE : state;
			default: next_state = piqu_pkg::PIQU_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			state <= piqu_pkg::PIQU_IDLE;
			busy <= 1'b0;
		end else begin
			state <= next_state;
			busy <= (next_state != piqu_pkg::PIQU_IDLE);
		end
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			leaf <= piqu_pkg::ZERO_WORD;
		end else if (accept) begin
			leaf <= query_leaf;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// leaf decode

	wire [15:0] sel = leaf[31:16];
	wire [15:0] fn = leaf[15:0];
	wire is_std = (sel == piqu_pkg::SEL_STD);
	wire is_ext = (sel == piqu_pkg::SEL_EXT);
	wire is_vnd = (sel == piqu_pkg::SEL_VND);

	wire hit_std_max = is_std && (fn == piqu_pkg::FN_MAX);
	wire hit_sig = is_std && (fn == piqu_pkg::FN_SIGNATURE);
	// the serial function exists only while the feature is on
	wire hit_serial = is_std && (fn == piqu_pkg::FN_SERIAL) && serial_number_feature;
	wire hit_ext_max = is_ext && (fn == piqu_pkg::FN_MAX);
	wire hit_name = is_ext && (fn >= piqu_pkg::FN_NAME_FIRST) && (fn <= piqu_pkg::FN_NAME_LAST);
	wire hit_vnd_max = is_vnd && (fn == piqu_pkg::FN_MAX);
	wire hit_info = is_vnd && (fn >= piqu_pkg::FN_INFO_FIRST) && (fn <= piqu_pkg::FN_INFO_LAST);
	wire hit_vendor = hit_std_max || hit_ext_max || hit_vnd_max;
	wire hit_long = hit_name || hit_info;

	wire [1:0] name_slot = 2'(fn[2:0] - piqu_pkg::NAME_BASE);
	wire [1:0] info_slot = 2'(fn[2:0] - piqu_pkg::INFO_BASE);

	////////////////////////////////////////////////////////////////////////////
	// string assembly

	// serial text: most significant digit is the first character
	logic [127:0] serial_text;
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_hex
			assign serial_text[gi*8 +: 8] = hex_char(serial_number[63 - gi*4 -: 4]);
		end
	endgenerate

	// sixteen characters per function, first fragment in EAX
	logic [31:0] long_w [4];
	generate
		for (gi = 0; gi < 4; gi++) begin : g_long
			assign long_w[gi] = hit_name ? name_word({name_slot, 2'(gi)}) :
				info_word({info_slot, 2'(gi)});
		end
	endgenerate

	wire [31:0] max_word = hit_std_max ? (serial_number_feature ? piqu_pkg::STD_MAX_SERIAL :
		piqu_pkg::STD_MAX_PLAIN) :
		hit_ext_max ? piqu_pkg::EXT_MAX : piqu_pkg::VND_MAX;

	// unlisted leaves fall through to zero in every register
	wire [31:0] next_eax = hit_vendor ? max_word :
		hit_sig ? piqu_pkg::SIG_EAX :
		hit_serial ? serial_text[31:0] :
		hit_long ? long_w[0] : piqu_pkg::ZERO_WORD;
	wire [31:0] next_ebx = hit_vendor ? piqu_pkg::VENDOR_EBX :
		hit_serial ? serial_text[63:32] :
		hit_long ? long_w[1] : piqu_pkg::ZERO_WORD;
	wire [31:0] next_ecx = hit_vendor ? piqu_pkg::VENDOR_ECX :
		hit_serial ? serial_text[95:64] :
		hit_long ? long_w[2] : piqu_pkg::ZERO_WORD;
	wire [31:0] next_edx = hit_vendor ? piqu_pkg::VENDOR_EDX :
		hit_sig ? (serial_number_feature ? piqu_pkg::SIG_EDX_SERIAL :
		piqu_pkg::SIG_EDX_PLAIN) :
		hit_serial ? serial_text[127:96] :
		hit_long ? long_w[3] : piqu_pkg::ZERO_WORD;

	////////////////////////////////////////////////////////////////////////////
	// result registers

	// one enable for all four words so no partial result is ever visible
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			res_eax <= piqu_pkg::ZERO_WORD;
			res_ebx <= piqu_pkg::ZERO_WORD;
			res_ecx <= piqu_pkg::ZERO_WORD;
			res_edx <= piqu_pkg::ZERO_WORD;
		end else if (complete) begin
			res_eax <= next_eax;
			res_ebx <= next_ebx;
			res_ecx <= next_ecx;
			res_edx <= next_edx;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			res_valid <= 1'b0;
		end else begin
			res_valid <= complete;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// identification support flag

	// plain read/write bit; software detects the query by flipping it
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			ident_support_flag <= 1'b0;
		end else if (flag_wr) begin
			ident_support_flag <= flag_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_sync_b);

	a_std_max_level: assert property (
		complete && (leaf == 32'h0000_0000)
		|=> res_valid && (res_eax == ($past(serial_number_feature) ? 32'h3 : 32'h1)))
		else $error("standard max level wrong");

	a_ext_set_decode: assert property (
		accept && (query_leaf == 32'h8000_0000) ##1 pipe_drained [*2]
		|-> ##1 (res_eax == 32'h8000_0004))
		else $error("extended set decode wrong");

	a_vnd_set_decode: assert property (
		complete && (leaf == 32'h8086_0000) |=> (res_eax == 32'h8086_0006))
		else $error("vendor set decode wrong");

	a_vendor_order: assert property (
		complete && hit_vendor |=> (res_ebx == 32'h756E_6547) &&
			(res_edx == 32'h5465_6E69) && (res_ecx == 32'h3638_784D))
		else $error("vendor fragment order wrong");

	a_reserved_zero: assert property (
		complete && !(hit_vendor || hit_sig || hit_serial || hit_long)
		|=> (res_eax == 32'h0) && (res_ebx == 32'h0) && (res_ecx == 32'h0) &&
			(res_edx == 32'h0))
		else $error("reserved leaf not zero");

	a_serialize_wait: assert property (
		(state == piqu_pkg::PIQU_DRAIN) && !pipe_drained |=> !res_valid && busy)
		else $error("result before drain");

	a_atomic_update: assert property (
		!complete |=> $stable(res_eax) && $stable(res_ebx) && $stable(res_ecx) &&
			$stable(res_edx))
		else $error("result changed outside completion");

	a_flag_persist: assert property (
		flag_wr ##1 !flag_wr |-> (ident_support_flag == $past(flag_wdata))
			##1 (ident_support_flag == $past(flag_wdata, 2)))
		else $error("support flag lost");

	a_serial_upper_hex: assert property (
		complete && hit_serial |=> (res_eax[7:0] <= 8'h39 ||
			(res_eax[7:0] >= 8'h41 && res_eax[7:0] <= 8'h46)) && (res_eax[7:0] >= 8'h30))
		else $error("serial text not upper hex");

	a_name_zero_fill: assert property (
		complete && (leaf == 32'h8000_0004)
		|=> (res_eax == 32'h0) && (res_edx == 32'h0))
		else $error("name fill not zero");

endmodule

`default_nettype wire

//--- hdl/piqu_pkg.sv
// constants for the processor identification query unit
// Contract
// - upper input half zero selects the standard function set
// - upper input half 8000h selects the extended function set
// - upper input half 8086h selects the vendor-specific function set
// - every query writes all four result registers
// - query runs at any privilege, completes only after earlier work drains
// - unsupported functions return zero in all four result registers
// - identification support flag toggles by software and keeps its value
// - unused default string characters are zero bytes
// - strings may fill their whole size with no terminator
// - vendor name functions return twelve characters in order EBX, EDX, ECX
// - long strings return sixteen characters per function in order EAX..EDX
// - serial number returned as upper-case hex text over EAX..EDX
// - default strings use only the shared graphic ASCII subset
// - standard function zero reports 3 with serial feature, else 1
package piqu_pkg;

	typedef enum logic [1:0] {
		PIQU_IDLE = 2'b00,
		PIQU_DRAIN = 2'b01
	} piqu_state_e;

	// function set selectors, upper half of the leaf
	localparam logic [15:0] SEL_STD = 16'h0000;
	localparam logic [15:0] SEL_EXT = 16'h8000;
	localparam logic [15:0] SEL_VND = 16'h8086;

	// function numbers, lower half of the leaf
	localparam logic [15:0] FN_MAX = 16'h0000;
	localparam logic [15:0] FN_SIGNATURE = 16'h0001;
	localparam logic [15:0] FN_SERIAL = 16'h0003;
	localparam logic [15:0] FN_NAME_FIRST = 16'h0002;
	localparam logic [15:0] FN_NAME_LAST = 16'h0004;
	localparam logic [15:0] FN_INFO_FIRST = 16'h0003;
	localparam logic [15:0] FN_INFO_LAST = 16'h0006;
	localparam logic [2:0] NAME_BASE = 3'h2;
	localparam logic [2:0] INFO_BASE = 3'h3;

	// highest function reported by each set
	localparam logic [31:0] STD_MAX_SERIAL = 32'h0000_0003;
	localparam logic [31:0] STD_MAX_PLAIN = 32'h0000_0001;
	localparam logic [31:0] EXT_MAX = 32'h8000_0004;
	localparam logic [31:0] VND_MAX = 32'h8086_0006;

	// vendor string after reset, fragments in EBX, EDX, ECX order
	localparam logic [31:0] VENDOR_EBX = 32'h756E_6547;
	localparam logic [31:0] VENDOR_EDX = 32'h5465_6E69;
	localparam logic [31:0] VENDOR_ECX = 32'h3638_784D;

	// signature function results
	localparam logic [31:0] SIG_EAX = 32'h0000_0543;
	localparam logic [31:0] SIG_EDX_SERIAL = 32'h0084_803F;
	localparam logic [31:0] SIG_EDX_PLAIN = 32'h0080_803F;

	// default processor name text, remaining words zero
	localparam logic [31:0] NAME_W0 = 32'h656E_6547;
	localparam logic [31:0] NAME_W1 = 32'h2063_6972;
	localparam logic [31:0] NAME_W2 = 32'h2036_3878;
	localparam logic [31:0] NAME_W3 = 32'h6572_6F63;
	// default information text, remaining words zero
	localparam logic [31:0] INFO_W0 = 32'h6976_6552;
	localparam logic [31:0] INFO_W1 = 32'h6E6F_6973;
	localparam logic [31:0] INFO_W2 = 32'h0000_3120;

	// hex text conversion offsets
	localparam logic [7:0] HEX_DIGIT_BASE = 8'h30;
	localparam logic [7:0] HEX_ALPHA_BASE = 8'h37;
	localparam logic [3:0] HEX_TEN = 4'hA;
	localparam logic [7:0] CHAR_ALPHA_HI = 8'h46;

	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

endpackage

//--- dv/piqu_pipe_model.sv
// model of earlier instructions still in flight ahead of a query
`timescale 1ns/1ps
`default_nettype none

module piqu_pipe_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic busy,
	input wire logic [3:0] lag,
	output logic pipe_drained
);
	logic [3:0] cnt;

	// drains lag cycles after the query turns busy; lag 0 means nothing is in flight
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= 4'h0;
			pipe_drained <= 1'b0;
		end else if (!busy) begin
			cnt <= 4'h0;
			pipe_drained <= (lag == 4'h0);
		end else begin
			cnt <= cnt + 4'h1;
			pipe_drained <= (cnt + 4'h1 >= lag);
		end
	end
endmodule

`default_nettype wire

//--- dv/tb.sv
// self-checking bench for the identification query unit
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic query_valid = 1'b0;
	logic [31:0] query_leaf = 32'h0000_0000;
	logic serial_number_feature = 1'b0;
	logic [63:0] serial_number = 64'h0;
	logic flag_wr = 1'b0;
	logic flag_wdata = 1'b0;
	logic [3:0] lag = 4'h0;
	logic pipe_drained, ident_support_flag, busy, res_valid;
	logic [31:0] res_eax, res_ebx, res_ecx, res_edx;
	logic [31:0] rng = 32'h19;
	int bad_count = 0;
	int n_tests = 0;
	localparam logic [31:0] LEAVES [21] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h4, 32'h8000_0000,
		32'h8000_0001, 32'h8000_0002, 32'h8000_0003, 32'h8000_0004, 32'h8000_0005,
		32'h8086_0000, 32'h8086_0001, 32'h8086_0002, 32'h8086_0003, 32'h8086_0004,
		32'h8086_0005, 32'h8086_0006, 32'h8086_0007, 32'h0001_0000, 32'h7FFF_0000};

	always #2.5 clk = ~clk;

	piqu_unit DUT (.clk(clk), .rst_b(rst_b), .query_valid(query_valid),
		.query_leaf(query_leaf), .pipe_drained(pipe_drained),
		.serial_number_feature(serial_number_feature), .serial_number(serial_number),
		.flag_wr(flag_wr), .flag_wdata(flag_wdata), .ident_support_flag(ident_support_flag),
		.busy(busy), .res_valid(res_valid), .res_eax(res_eax), .res_ebx(res_ebx),
		.res_ecx(res_ecx), .res_edx(res_edx));
	piqu_pipe_model PIPE (.clk(clk), .rst_b(rst_b), .busy(busy), .lag(lag),
		.pipe_drained(pipe_drained));

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	// result as {eax, ebx, ecx, edx}
	function automatic logic [127:0] expect_res(logic [31:0] leaf, logic feat, logic [63:0] sn);
		logic [127:0] r;
		logic [3:0] nib;
		logic [95:0] vnd;
		r = 128'h0;
		vnd = {piqu_pkg::VENDOR_EBX, piqu_pkg::VENDOR_ECX, piqu_pkg::VENDOR_EDX};
		case (leaf)
			32'h0000_0000: r = {(feat ? 32'h3 : 32'h1), vnd};
			32'h0000_0001: r = {piqu_pkg::SIG_EAX, 64'h0,
				(feat ? piqu_pkg::SIG_EDX_SERIAL : piqu_pkg::SIG_EDX_PLAIN)};
			32'h0000_0003: begin
				for (int i = 0; i < 16; i++) begin
					nib = sn[63 - 4 * i -: 4];
					// first character lands in eax bits 7:0
					r[103 - 32 * (i / 4) + 8 * (i % 4) -: 8] = (nib < 4'hA) ?
						8'h30 + {4'h0, nib} : 8'h37 + {4'h0, nib};
				end
				if (!feat) r = 128'h0;
			end
			32'h8000_0000: r = {piqu_pkg::EXT_MAX, vnd};
			32'h8000_0002: r = {piqu_pkg::NAME_W0, piqu_pkg::NAME_W1, piqu_pkg::NAME_W2,
				piqu_pkg::NAME_W3};
			32'h8086_0000: r = {piqu_pkg::VND_MAX, vnd};
			32'h8086_0003: r = {piqu_pkg::INFO_W0, piqu_pkg::INFO_W1, piqu_pkg::INFO_W2,
				32'h0};
			default: r = 128'h0;
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	task automatic check_word(logic [31:0] got, logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: result word %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic check_bit(logic got, logic exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
		end
	endtask

	// issues one query; for a nonzero dly, pokes a second one while busy that must be ignored
	task automatic query(logic [31:0] leaf, logic [3:0] dly);
		logic [127:0] e;
		int n;
		e = expect_res(leaf, serial_number_feature, serial_number);
		lag = dly;
		query_leaf = leaf;
		query_valid = 1'b1;
		@(negedge clk);
		n = 1;
		check_bit(busy, 1'b1);
		while (res_valid !== 1'b1 && n < 40) begin
			query_valid = (n == 2);
			if (n == 2) query_leaf = ~leaf;
			@(negedge clk);
			n++;
		end
		query_valid = 1'b0;
		check_bit(res_valid, 1'b1);
		check_bit(busy, 1'b0);
		check_bit(n == int'(dly) + 2, 1'b1);
		check_word(res_eax, e[127:96]);
		check_word(res_ebx, e[95:64]);
		check_word(res_ecx, e[63:32]);
		check_word(res_edx, e[31:0]);
		repeat (3) begin
			@(negedge clk);
			check_bit(res_valid, 1'b0);
		end
	endtask

	task automatic final_report();
		$display("comparisons %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		final_report();
	end

	initial begin
		logic [31:0] v;
		repeat (20) @(negedge clk);
		rst_b = 1'b1;
		repeat (3) @(negedge clk);
		check_bit(ident_support_flag, 1'b0);
		// software proves the flag toggles before any query
		for (int i = 0; i < 3; i++) begin
			flag_wr = 1'b1;
			flag_wdata = ~i[0];
			@(negedge clk);
			check_bit(ident_support_flag, ~i[0]);
		end
		flag_wr = 1'b0;
		repeat (4) @(negedge clk);
		check_bit(ident_support_flag, 1'b1);
		for (int f = 0; f < 2; f++) begin
			serial_number_feature = f[0];
			for (int k = 0; k < 21; k++) begin
				serial_number = {xs(), xs()};
				query(LEAVES[k], 4'(xs() % 6));
			end
		end
		serial_number = 64'hFEDC_BA98_7654_3210;
		query(32'h0000_0003, 4'h0);
		for (int r = 0; r < 300; r++) begin
			v = xs();
			serial_number_feature = v[8];
			serial_number = {xs(), xs()};
			query({(v[1:0] == 2'h0) ? 16'h0 : (v[1:0] == 2'h1) ? 16'h8000 :
				(v[1:0] == 2'h2) ? 16'h8086 : v[31:16], 13'h0, v[4:2]},
				4'(v[7:5] % 6));
		end
		final_report();
	end
endmodule

`default_nettype wire
